// File: src/crf_pkg.sv
// constants, field layouts and carriers for the can receive filter and fifo status block
// Notes on behaviour
// - tx fifo: empty flag set when nothing queued, clear otherwise
// - rx fifo: same flag shows full when every slot is taken
// - tx fifo: half flag set while occupancy is at most half the depth
// - rx fifo: half flag set while occupancy is at least half the depth
// - tx fifo: low flag set while a free slot remains
// - rx fifo: low flag set while at least one message is held
// - message index runs zero up to depth minus one
// - outcome bits clear on send request set or on a zero written
// - outcome bits otherwise change only on completion, abort or fifo reset
// - tx user address points at the head, next slot to write
// - rx user address points at the tail, next slot to read
// - four filters per control word, enable at top of each byte
// - five-bit destination pointer names the receiving fifo 1 to 31
// - pointer zero is reserved; nothing is ever stored in fifo zero
// - destination pointer changes only while its filter is disabled
// - filter object changes only while its filter is disabled
// - frame-type match set: extended select picks extended or standard only
// - frame-type match clear: both frame types match on identifier bits
// - object and mask share layout: ext bit 29, eid 28:11, sid 10:0
// - data-byte mode compares eid fields with first 18 data bits of standard frames
// - direction bit 7 set means transmit, clear means receive
// - depth field holds depth minus one, one to thirty-two messages
package crf_pkg;
  // register regions, word index, region in addr[7:5]
  localparam logic [2:0] RGN_FLTCON  = 3'h0;
  localparam logic [2:0] RGN_FLTOBJ  = 3'h1;
  localparam logic [2:0] RGN_MASK    = 3'h2;
  localparam logic [2:0] RGN_FIFOCON = 3'h3;
  localparam logic [2:0] RGN_FIFOSTA = 3'h4;
  localparam logic [2:0] RGN_USER_ADDRESS_FIELD  = 3'h5;
  // fifo control fields
  localparam int CTL_DIR    = 7;
  localparam int CTL_UINC   = 8;
  localparam int CTL_SEND   = 9;
  localparam int CTL_FRESET = 10;
  localparam int CTL_DEPTH  = 24;
  // fifo status fields
  localparam int STA_ABT  = 7;
  localparam int STA_LARB = 6;
  localparam int STA_ERR  = 5;
  localparam int STA_IDX  = 8;
  localparam int STA_EF   = 2;
  localparam int STA_HL   = 1;
  localparam int STA_NF   = 0;
  // filter control byte and object/mask fields
  localparam int FLT_EN   = 7;
  localparam int OBJ_TYPE = 30;
  localparam int OBJ_XT   = 29;
  localparam int OBJ_EID  = 11;
  localparam logic [31:0] OBJ_WMASK = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  // message ram layout
  localparam logic [31:0] RAM_BASE    = 32'h0000_0400;
  localparam logic [31:0] FIFO_STRIDE = 32'h0000_0200;
  localparam logic [31:0] OBJ_BYTES   = 32'h0000_0010;

  typedef struct packed {
    logic       dir;
    logic [4:0] depth;
    logic       send_req;
  } crf_cfg_s;

  typedef struct packed {
    logic [5:0] occ;
    logic [4:0] head;
    logic [4:0] tail;
    logic       abt;
    logic       larb;
    logic       err;
  } crf_st_s;

  typedef struct packed {
    logic        ide;
    logic        xt;
    logic [17:0] extended_id_bits;
    logic [10:0] standard_id_bits;
    logic [17:0] data18;
  } crf_rxid_s;

  typedef struct packed {
    logic       done;
    logic       aborted;
    logic       larb;
    logic       err;
    logic [4:0] fifo;
  } crf_txev_s;
endpackage : crf_pkg

// File: src/crf_match.sv
// one acceptance filter compare
`timescale 1ns/10ps
module crf_match (
  input  wire logic             en_in,
  input  wire logic [31:0]      obj_in,
  input  wire logic [31:0]      mask_in,
  input  wire logic             data_mode_in,
  input  crf_pkg::crf_rxid_s    id_in,
  output logic                  hit_out
);
  logic [29:0] rx_bits;
  logic [29:0] cmp_mask;
  logic        type_ok;

  // received bits in object layout, eid slot carries data in data mode for standard frames
  always_comb begin
    rx_bits = {id_in.xt, id_in.extended_id_bits, id_in.standard_id_bits};
    if (data_mode_in && !id_in.ide) begin
      rx_bits[28:0] = {id_in.data18, id_in.standard_id_bits};
    end
    cmp_mask = mask_in[29:0];
    if (!id_in.ide && !data_mode_in) begin
      cmp_mask[28:11] = 18'h0_0000;
    end
    type_ok = !mask_in[crf_pkg::OBJ_TYPE]
              || (obj_in[crf_pkg::OBJ_TYPE] == id_in.ide);
    hit_out = en_in && type_ok && (((rx_bits ^ obj_in[29:0]) & cmp_mask) == 30'h0);
  end
endmodule : crf_match

// File: src/crf_top.sv
// filter tables, fifo state and register view
`timescale 1ns/10ps
module crf_top #(
  parameter int NUM_FILT = 32,
  parameter int NUM_FIFO = 31
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             config_mode_in,
  input  wire logic             data_mode_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic             reg_wr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_rd_in,
  output logic [31:0]           reg_rdata_out,
  output logic                  reg_rvalid_out,
  input  wire logic             rx_valid_in,
  input  crf_pkg::crf_rxid_s    rx_id_in,
  input  crf_pkg::crf_txev_s    tx_ev_in,
  output logic                  rx_store_out,
  output logic                  rx_drop_out,
  output logic [4:0]            rx_fifo_out,
  output logic [4:0]            rx_hit_out,
  output logic [31:0]           rx_addr_out,
  output logic [31:0]           tx_pend_out,
  output logic [31:0]           tx_abort_req_out
);
  if (NUM_FILT < 4 || NUM_FILT > 32 || (NUM_FILT % 4) != 0) begin : g_chk_filt
    $error("NUM_FILT must be 4..32 in steps of 4");
  end
  if (NUM_FIFO < 1 || NUM_FIFO > 31) begin : g_chk_fifo
    $error("NUM_FIFO must be 1..31");
  end

  crf_pkg::crf_cfg_s cfg_r   [0:31];
  crf_pkg::crf_cfg_s cfg_nxt [0:31];
  crf_pkg::crf_st_s  st_r    [0:31];
  crf_pkg::crf_st_s  st_nxt  [0:31];
  logic              flt_en_r   [0:31];
  logic              flt_en_nxt [0:31];
  logic [4:0]        flt_ptr_r  [0:31];
  logic [4:0]        flt_ptr_nxt[0:31];
  logic [31:0]       obj_r      [0:31];
  logic [31:0]       obj_nxt    [0:31];
  logic [31:0]       mask_r     [0:31];
  logic [31:0]       mask_nxt   [0:31];
  logic [31:0]       hit_vec;
  logic [31:0]       abort_nxt;
  logic [31:0]       pend_nxt;
  logic [2:0]        rgn;
  logic [4:0]        idx;
  logic [4:0]        win;
  logic              any_hit;
  logic [4:0]        tgt;
  logic              store_now;
  logic              drop_now;
  logic [31:0]       rdata_nxt;

  assign rgn = reg_addr_in[7:5];
  assign idx = reg_addr_in[4:0];

  // depth as a message count
  function automatic logic [5:0] slots(input crf_pkg::crf_cfg_s c);
    slots = {1'b0, c.depth} + 6'h01;
  endfunction : slots

  // ring pointer advance with wrap at depth
  function automatic logic [4:0] bump(input logic [4:0] p, input logic [4:0] d);
    bump = (p == d) ? 5'h00 : p + 5'h01;
  endfunction : bump

  // ram address of a slot in a fifo
  function automatic logic [31:0] slot_addr(input logic [4:0] f, input logic [4:0] s);
    slot_addr = crf_pkg::RAM_BASE + {27'h0, f} * crf_pkg::FIFO_STRIDE
                + {27'h0, s} * crf_pkg::OBJ_BYTES;
  endfunction : slot_addr

  // live fill-level flags in status layout
  function automatic logic [2:0] flags(input crf_pkg::crf_cfg_s c, input crf_pkg::crf_st_s s);
    logic [6:0] twice;
    twice = {s.occ, 1'b0};
    if (c.dir) begin
      flags = {s.occ == 6'h00,
               twice <= {1'b0, slots(c)},
               s.occ < slots(c)};
    end else begin
      flags = {s.occ == slots(c),
               twice >= {1'b0, slots(c)},
               s.occ != 6'h00};
    end
  endfunction : flags

  // filter compare units
  genvar gi;
  for (gi = 0; gi < 32; gi++) begin : g_flt
    if (gi < NUM_FILT) begin : g_on
      crf_match u_match (
        .en_in        (flt_en_r[gi]),
        .obj_in       (obj_r[gi]),
        .mask_in      (mask_r[gi]),
        .data_mode_in (data_mode_in),
        .id_in        (rx_id_in),
        .hit_out      (hit_vec[gi])
      );
    end else begin : g_off
      assign hit_vec[gi] = 1'b0;
    end
  end

  // lowest matching filter and store decision
  always_comb begin
    win = 5'h00;
    any_hit = 1'b0;
    for (int f = 31; f >= 0; f--) begin
      if (hit_vec[f]) begin
        win = 5'(f);
        any_hit = 1'b1;
      end
    end
    tgt = flt_ptr_r[win];
    store_now = rx_valid_in && any_hit && (tgt != 5'h00)
                && ({27'h0, tgt} <= 32'(NUM_FIFO)) && !cfg_r[tgt].dir
                && (st_r[tgt].occ < slots(cfg_r[tgt]));
    drop_now = rx_valid_in && !store_now;
  end

  // filter table next values
  always_comb begin
    for (int f = 0; f < 32; f++) begin
      flt_en_nxt[f]  = flt_en_r[f];
      flt_ptr_nxt[f] = flt_ptr_r[f];
      obj_nxt[f]     = obj_r[f];
      mask_nxt[f]    = mask_r[f];
      if (reg_wr_in && rgn == crf_pkg::RGN_FLTCON && idx == 5'(f / 4) && f < NUM_FILT) begin
        flt_en_nxt[f] = reg_wdata_in[(f % 4) * 8 + crf_pkg::FLT_EN];
        if (!flt_en_r[f]) begin
          flt_ptr_nxt[f] = reg_wdata_in[(f % 4) * 8 +: 5];
        end
      end
      if (reg_wr_in && rgn == crf_pkg::RGN_FLTOBJ && idx == 5'(f) && !flt_en_r[f]) begin
        obj_nxt[f] = reg_wdata_in & crf_pkg::OBJ_WMASK;
      end
      if (reg_wr_in && rgn == crf_pkg::RGN_MASK && idx == 5'(f)) begin
        mask_nxt[f] = reg_wdata_in & crf_pkg::OBJ_WMASK;
      end
    end
  end

  // filter table registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int f = 0; f < 32; f++) begin
        flt_en_r[f]  <= 1'b0;
        flt_ptr_r[f] <= 5'h00;
        obj_r[f]     <= crf_pkg::RST_WORD;
        mask_r[f]    <= crf_pkg::RST_WORD;
      end
    end else begin
      for (int f = 0; f < 32; f++) begin
        flt_en_r[f]  <= flt_en_nxt[f];
        flt_ptr_r[f] <= flt_ptr_nxt[f];
        obj_r[f]     <= obj_nxt[f];
        mask_r[f]    <= mask_nxt[f];
      end
    end
  end

  // fifo state next values
  always_comb begin
    logic wr_ctl;
    logic wr_sta;
    logic inc;
    logic dec;
    logic txd;
    wr_ctl = 1'b0;
    wr_sta = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    txd = 1'b0;
    abort_nxt = 32'h0000_0000;
    pend_nxt = 32'h0000_0000;
    for (int m = 0; m < 32; m++) begin
      cfg_nxt[m] = cfg_r[m];
      st_nxt[m]  = st_r[m];
      wr_ctl = reg_wr_in && rgn == crf_pkg::RGN_FIFOCON && idx == 5'(m);
      wr_sta = reg_wr_in && rgn == crf_pkg::RGN_FIFOSTA && idx == 5'(m);
      txd = tx_ev_in.done && tx_ev_in.fifo == 5'(m) && cfg_r[m].dir;
      inc = 1'b0;
      dec = 1'b0;
      if (m >= 1 && m <= NUM_FIFO) begin
        if (wr_ctl && config_mode_in) begin
          cfg_nxt[m].dir   = reg_wdata_in[crf_pkg::CTL_DIR];
          cfg_nxt[m].depth = reg_wdata_in[crf_pkg::CTL_DEPTH +: 5];
        end
        // host writes zero to outcome bits
        if (wr_sta) begin
          st_nxt[m].abt  = st_r[m].abt  & reg_wdata_in[crf_pkg::STA_ABT];
          st_nxt[m].larb = st_r[m].larb & reg_wdata_in[crf_pkg::STA_LARB];
          st_nxt[m].err  = st_r[m].err  & reg_wdata_in[crf_pkg::STA_ERR];
        end
        if (wr_ctl && cfg_r[m].dir) begin
          if (reg_wdata_in[crf_pkg::CTL_SEND]) begin
            cfg_nxt[m].send_req = 1'b1;
            st_nxt[m].abt  = 1'b0;
            st_nxt[m].larb = 1'b0;
            st_nxt[m].err  = 1'b0;
          end else if (cfg_r[m].send_req) begin
            abort_nxt[m] = 1'b1;
          end
        end
        if (wr_ctl && reg_wdata_in[crf_pkg::CTL_UINC]) begin
          if (cfg_r[m].dir && st_r[m].occ < slots(cfg_r[m])) begin
            inc = 1'b1;
          end
          if (!cfg_r[m].dir && st_r[m].occ != 6'h00) begin
            dec = 1'b1;
          end
        end
        if (store_now && tgt == 5'(m)) begin
          inc = 1'b1;
        end
        // outcome of a finished or aborted message, wins over host clear
        if (txd) begin
          st_nxt[m].abt  = tx_ev_in.aborted;
          st_nxt[m].larb = tx_ev_in.larb;
          st_nxt[m].err  = tx_ev_in.err;
          if (tx_ev_in.aborted) begin
            cfg_nxt[m].send_req = 1'b0;
          end else if (st_r[m].occ != 6'h00) begin
            dec = 1'b1;
          end
        end
        st_nxt[m].occ = st_r[m].occ + {5'h00, inc} - {5'h00, dec};
        if (inc) begin
          st_nxt[m].head = bump(st_r[m].head, cfg_r[m].depth);
        end
        if (dec) begin
          st_nxt[m].tail = bump(st_r[m].tail, cfg_r[m].depth);
        end
        if (txd && st_nxt[m].occ == 6'h00) begin
          cfg_nxt[m].send_req = 1'b0;
        end
        // fifo reset empties the ring and clears outcome
        if ((wr_ctl && reg_wdata_in[crf_pkg::CTL_FRESET]) || (wr_ctl && config_mode_in
            && reg_wdata_in[crf_pkg::CTL_DEPTH +: 5] != cfg_r[m].depth)) begin
          st_nxt[m] = '0;
          cfg_nxt[m].send_req = 1'b0;
        end
        pend_nxt[m] = cfg_nxt[m].send_req;
      end
    end
  end

  // fifo state registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int m = 0; m < 32; m++) begin
        cfg_r[m] <= '0;
        st_r[m]  <= '0;
      end
    end else begin
      for (int m = 0; m < 32; m++) begin
        cfg_r[m] <= cfg_nxt[m];
        st_r[m]  <= st_nxt[m];
      end
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (rgn)
      crf_pkg::RGN_FLTCON: begin
        for (int b = 0; b < 4; b++) begin
          if ({27'h0, idx} * 4 + b < NUM_FILT) begin
            rdata_nxt[b * 8 + crf_pkg::FLT_EN] = flt_en_r[{idx[2:0], 2'(b)}];
            rdata_nxt[b * 8 +: 5] = flt_ptr_r[{idx[2:0], 2'(b)}];
          end
        end
      end
      crf_pkg::RGN_FLTOBJ: rdata_nxt = obj_r[idx];
      crf_pkg::RGN_MASK:   rdata_nxt = mask_r[idx];
      crf_pkg::RGN_FIFOCON: begin
        rdata_nxt[crf_pkg::CTL_DIR]       = cfg_r[idx].dir;
        rdata_nxt[crf_pkg::CTL_SEND]      = cfg_r[idx].send_req;
        rdata_nxt[crf_pkg::CTL_DEPTH +: 5] = cfg_r[idx].depth;
      end
      crf_pkg::RGN_FIFOSTA: begin
        rdata_nxt[crf_pkg::STA_IDX +: 5] = cfg_r[idx].dir ? st_r[idx].tail : st_r[idx].head;
        rdata_nxt[crf_pkg::STA_ABT]  = st_r[idx].abt;
        rdata_nxt[crf_pkg::STA_LARB] = st_r[idx].larb;
        rdata_nxt[crf_pkg::STA_ERR]  = st_r[idx].err;
        rdata_nxt[2:0] = flags(cfg_r[idx], st_r[idx]);
      end
      crf_pkg::RGN_USER_ADDRESS_FIELD: begin
        if (idx != 5'h00) begin
          rdata_nxt = slot_addr(idx, cfg_r[idx].dir ? st_r[idx].head
                                                    : st_r[idx].tail);
        end
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
    if (!reg_rd_in || (idx == 5'h00 && rgn >= crf_pkg::RGN_FIFOCON)
        || ({27'h0, idx} > 32'(NUM_FIFO) && rgn >= crf_pkg::RGN_FIFOCON)) begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out    <= 32'h0000_0000;
      reg_rvalid_out   <= 1'b0;
      rx_store_out     <= 1'b0;
      rx_drop_out      <= 1'b0;
      rx_fifo_out      <= 5'h00;
      rx_hit_out       <= 5'h00;
      rx_addr_out      <= 32'h0000_0000;
      tx_pend_out      <= 32'h0000_0000;
      tx_abort_req_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out    <= rdata_nxt;
      reg_rvalid_out   <= reg_rd_in;
      rx_store_out     <= store_now;
      rx_drop_out      <= drop_now;
      rx_fifo_out      <= store_now ? tgt : 5'h00;
      rx_hit_out       <= win;
      rx_addr_out      <= slot_addr(tgt, st_r[tgt].head);
      tx_pend_out      <= pend_nxt;
      tx_abort_req_out <= abort_nxt;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_no_fifo_zero: assert property (rx_store_out |-> rx_fifo_out != 5'h00)
    else $error("stored into fifo zero");
  a_store_cause: assert property (rx_store_out |-> $past(rx_valid_in && any_hit))
    else $error("store without enabled hit");
  a_lowest_hit: assert property (rx_store_out |->
      ($past(hit_vec) & ((32'h1 << rx_hit_out) - 32'h1)) == 32'h0)
    else $error("lower filter also hit");
  a_ptr_locked: assert property (flt_en_r[0] |=> $stable(flt_ptr_r[0]))
    else $error("pointer changed while enabled");
  a_obj_locked: assert property (flt_en_r[1] |=> $stable(obj_r[1]))
    else $error("object changed while enabled");
  a_send_clear: assert property (reg_wr_in && rgn == crf_pkg::RGN_FIFOCON && idx == 5'h02
      && reg_wdata_in[crf_pkg::CTL_SEND] && cfg_r[2].dir && !tx_ev_in.done
      |=> !st_r[2].abt && !st_r[2].larb && !st_r[2].err)
    else $error("outcome kept after send request");
  a_outcome_hold: assert property (!tx_ev_in.done && !reg_wr_in
      |=> $stable({st_r[2].abt, st_r[2].larb, st_r[2].err}))
    else $error("outcome changed without cause");
  a_occ_bound: assert property (st_r[1].occ <= slots(cfg_r[1])
      && st_r[1].head <= cfg_r[1].depth)
    else $error("occupancy or index beyond depth");
  a_ua_read: assert property (reg_rd_in && rgn == crf_pkg::RGN_USER_ADDRESS_FIELD && idx == 5'h02
      && cfg_r[2].dir |=> reg_rdata_out == slot_addr(5'h02, $past(st_r[2].head)))
    else $error("tx user address not at head");
  a_empty_read: assert property (reg_rd_in && rgn == crf_pkg::RGN_FIFOSTA && idx == 5'h02
      && cfg_r[2].dir && st_r[2].occ == 6'h00 |=> reg_rdata_out[2:0] == 3'h7)
    else $error("empty tx fifo flags wrong");

  c_rx_store: cover property (rx_valid_in ##1 rx_store_out);
  c_rx_drop:  cover property (rx_drop_out);
  c_tx_done:  cover property (tx_ev_in.done && cfg_r[2].dir ##1 !cfg_r[2].send_req);
  c_abort:    cover property (tx_abort_req_out != 32'h0);
endmodule : crf_top

// File: verification/crf_far_model.sv
// far side model: received frames and transmit outcomes
`timescale 1ns/10ps
module crf_far_model (
  input  wire logic          clk_in,
  output logic               rx_valid_out,
  output crf_pkg::crf_rxid_s rx_id_out,
  output crf_pkg::crf_txev_s tx_ev_out
);
  // idle values at time zero
  initial begin
    rx_valid_out = 1'b0;
    rx_id_out = '0;
    tx_ev_out = '0;
  end
  // one frame for one cycle, id inverted once released so stale values differ from the frame
  task automatic frame(input crf_pkg::crf_rxid_s id);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_id_out <= id;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_id_out <= ~id;
  endtask : frame
  // one transmit outcome pulse
  task automatic tx_done(input crf_pkg::crf_txev_s ev);
    @(posedge clk_in);
    tx_ev_out <= ev;
    @(posedge clk_in);
    tx_ev_out <= '0;
  endtask : tx_done
endmodule : crf_far_model

// File: verification/can_rx_filter_fifo_status_tb.sv
// self-checking bench for the receive filter and fifo status block
`timescale 1ns/10ps
module can_rx_filter_fifo_status_tb;
  logic               ref_clk_in = 1'b0;
  logic               sys_rst_in = 1'b1;
  logic               cfg_mode   = 1'b0;
  logic               dmode      = 1'b0;
  logic [7:0]         addr       = 8'h00;
  logic               wr         = 1'b0;
  logic [31:0]        wdata      = 32'h0000_0000;
  logic               rd         = 1'b0;
  logic [31:0]        rdata;
  logic               rvalid;
  logic               rx_valid;
  crf_pkg::crf_rxid_s rx_id;
  crf_pkg::crf_txev_s tx_ev;
  logic               store;
  logic               drop;
  logic [4:0]         rfifo;
  logic [4:0]         rhit;
  logic [31:0]        raddr;
  logic [31:0]        pend;
  logic [31:0]        abreq;
  logic [10:0]        standard_id_bits;
  int                 failures    = 0;
  int                 checks_done = 0;
  int                 seed        = 53513;
  int                 cycles      = 0;
  int                 i;

  always #25 ref_clk_in = ~ref_clk_in;

  crf_top dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .config_mode_in(cfg_mode),
    .data_mode_in(dmode), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .rx_valid_in(rx_valid), .rx_id_in(rx_id),
    .tx_ev_in(tx_ev), .rx_store_out(store), .rx_drop_out(drop), .rx_fifo_out(rfifo), .rx_hit_out(rhit),
    .rx_addr_out(raddr), .tx_pend_out(pend), .tx_abort_req_out(abreq));

  crf_far_model far_u (.clk_in(ref_clk_in), .rx_valid_out(rx_valid), .rx_id_out(rx_id), .tx_ev_out(tx_ev));

  // expected fill flags from occupancy and depth
  function automatic logic [2:0] exp_flags(input logic tx, input int occ, input int dep);
    if (tx) return {occ == 0, occ * 2 <= dep, occ != dep};
    return {occ == dep, occ * 2 >= dep, occ != 0};
  endfunction : exp_flags
  // expected message ram address of a slot
  function automatic logic [31:0] exp_ua(input int m, input int slot);
    return crf_pkg::RAM_BASE + 32'(m) * crf_pkg::FIFO_STRIDE + 32'(slot) * crf_pkg::OBJ_BYTES;
  endfunction : exp_ua
  // expected status word
  function automatic logic [31:0] sta(input int idx, input logic [2:0] oc, input logic [2:0] fl);
    return {19'h0, 5'(idx), oc, 2'b00, fl};
  endfunction : sta

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] rg, input logic [4:0] ix, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= {rg, ix};
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // read strobe one cycle, data taken while rvalid stands
  task automatic rd_chk(input logic [2:0] rg, input logic [4:0] ix, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr <= {rg, ix};
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    chk((rvalid === 1'b1) ? rdata : 32'hDEAD_BEEF, e);
  endtask : rd_chk
  // one frame, then the store or drop answer one cycle later
  task automatic rx_chk(input crf_pkg::crf_rxid_s id, input logic [4:0] f, input logic [4:0] h,
                        input logic [31:0] a);
    far_u.frame(id);
    #1;
    chk({store, drop, rfifo, rhit}, {f != 5'h00, f == 5'h00, f, h});
    if (f != 5'h00) chk(raddr, a);
  endtask : rx_chk

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(crf_pkg::RGN_FLTCON, 5'h00, crf_pkg::RST_WORD);
    rd_chk(crf_pkg::RGN_FLTOBJ, 5'h05, crf_pkg::RST_WORD);
    rd_chk(crf_pkg::RGN_MASK, 5'h05, crf_pkg::RST_WORD);
    rd_chk(3'h6, 5'h00, 32'h0000_0000);
    $display("test reset done");
    // fifo 1 rx four deep, fifo 2 tx two deep, fifo 3 rx thirty-two deep
    @(posedge ref_clk_in);
    cfg_mode <= 1'b1;
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h01, 32'h0300_0000);
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h02, 32'h0100_0080);
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h03, 32'h1F00_0000);
    cfg_mode <= 1'b0;
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(0, 3'b000, exp_flags(1'b1, 0, 2)));
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h01, sta(0, 3'b000, exp_flags(1'b0, 0, 4)));
    rd_chk(crf_pkg::RGN_USER_ADDRESS_FIELD, 5'h01, exp_ua(1, 0));
    // filter 0 on a random standard id, to fifo 1
    standard_id_bits = 11'($random(seed));
    wr_reg(crf_pkg::RGN_MASK, 5'h00, 32'h0000_07FF);
    wr_reg(crf_pkg::RGN_FLTOBJ, 5'h00, {21'h0, standard_id_bits});
    wr_reg(crf_pkg::RGN_FLTCON, 5'h00, 32'h0000_0081);
    wr_reg(crf_pkg::RGN_FLTCON, 5'h00, 32'h0000_0085);
    rd_chk(crf_pkg::RGN_FLTCON, 5'h00, 32'h0000_0081);
    wr_reg(crf_pkg::RGN_FLTOBJ, 5'h00, 32'h0000_0000);
    rd_chk(crf_pkg::RGN_FLTOBJ, 5'h00, {21'h0, standard_id_bits});
    rx_chk('{1'b0, 1'b0, 18'h0, standard_id_bits ^ 11'h001, 18'h0}, 5'h00, 5'h00, 32'h0);
    // fill fifo 1 to refusal
    for (i = 0; i < 5; i++) begin
      rx_chk('{1'b0, 1'b0, 18'($random(seed)), standard_id_bits, 18'($random(seed))}, (i < 4) ? 5'h01 : 5'h00, 5'h00,
             exp_ua(1, i));
      rd_chk(crf_pkg::RGN_FIFOSTA, 5'h01, sta(((i < 4) ? i + 1 : 4) % 4, 3'b000,
             exp_flags(1'b0, (i < 4) ? i + 1 : 4, 4)));
    end
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h01, 32'h0000_0100);
    rd_chk(crf_pkg::RGN_USER_ADDRESS_FIELD, 5'h01, exp_ua(1, 1));
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h01, sta(0, 3'b000, exp_flags(1'b0, 3, 4)));
    $display("test rx fill done");
    // filter 1 extended only to fifo 3, filter 2 catch-all on reserved pointer
    wr_reg(crf_pkg::RGN_MASK, 5'h01, 32'h4000_07FF);
    wr_reg(crf_pkg::RGN_FLTOBJ, 5'h01, {21'h080000, ~standard_id_bits});
    wr_reg(crf_pkg::RGN_MASK, 5'h02, 32'h0000_0000);
    wr_reg(crf_pkg::RGN_FLTCON, 5'h00, 32'h0080_8381);
    rx_chk('{1'b0, 1'b0, 18'h0, ~standard_id_bits, 18'h0}, 5'h00, 5'h02, 32'h0);
    rx_chk('{1'b1, 1'b0, 18'($random(seed)), ~standard_id_bits, 18'h0}, 5'h03, 5'h01, exp_ua(3, 0));
    wr_reg(crf_pkg::RGN_MASK, 5'h01, 32'h0000_07FF);
    rx_chk('{1'b0, 1'b0, 18'h0, ~standard_id_bits, 18'h0}, 5'h03, 5'h01, exp_ua(3, 1));
    // data-byte mode: extended fields against the first data bits
    wr_reg(crf_pkg::RGN_MASK, 5'h01, 32'h1FFF_F800);
    dmode <= 1'b1;
    rx_chk('{1'b0, 1'b0, 18'h3FFFF, {~standard_id_bits[10], 10'($random(seed))}, 18'h0}, 5'h03, 5'h01, exp_ua(3, 2));
    rx_chk('{1'b0, 1'b0, 18'h0, {~standard_id_bits[10], 10'($random(seed))}, 18'h1}, 5'h00, 5'h02, 32'h0);
    dmode <= 1'b0;
    $display("test filter done");
    // tx fifo 2: queue two, send, outcomes
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h02, 32'h0000_0100);
    rd_chk(crf_pkg::RGN_USER_ADDRESS_FIELD, 5'h02, exp_ua(2, 1));
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(0, 3'b000, exp_flags(1'b1, 1, 2)));
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h02, 32'h0000_0100);
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(0, 3'b000, exp_flags(1'b1, 2, 2)));
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h02, 32'h0000_0200);
    chk(pend, 32'h0000_0004);
    far_u.tx_done('{1'b1, 1'b0, 1'b1, 1'b0, 5'h02});
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(1, 3'b010, exp_flags(1'b1, 1, 2)));
    chk(pend, 32'h0000_0004);
    wr_reg(crf_pkg::RGN_FIFOSTA, 5'h02, 32'h0000_0000);
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(1, 3'b000, exp_flags(1'b1, 1, 2)));
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h02, 32'h0000_0000);
    chk(abreq, 32'h0000_0004);
    far_u.tx_done('{1'b1, 1'b1, 1'b0, 1'b1, 5'h02});
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(1, 3'b101, exp_flags(1'b1, 1, 2)));
    wr_reg(crf_pkg::RGN_FIFOCON, 5'h02, 32'h0000_0200);
    rd_chk(crf_pkg::RGN_FIFOSTA, 5'h02, sta(1, 3'b000, exp_flags(1'b1, 1, 2)));
    $display("test tx done");
    tally_and_finish();
  end
endmodule : can_rx_filter_fifo_status_tb
